//--- ddss_defs.svh
// Purpose: constants for the drive status sense block
// Assumes: one selected drive reported at a time
// Notes: offsets, field positions and byte values
//
// Overview of operation
// - bit 15 set on fault, seek check, not-ready
// - bits 12-9 report disc type encoding
// - attention on seek end or post-End change
// - attention cleared by status read
// - bit 6 follows write protect notch
// - drive fault on not-ready after End or during transfer, or hardware failure
// - drive fault cleared by status read
// - first status on disc after power/door/test
// - first status cleared by status read
// - seek check on any of three seek failures
// - seek check cleared by status read
// - bits 1,0 encode drive readiness
// - no-drive state latched at power-on only
// - clean status gives zero error and jump
// - short read: poll re-enabled only by Untalk
// - over-read sends one byte 1 with EOI
// - logical address: cyl hi, cyl lo, head, sector
// - status-word condition gives error code 10011
`ifndef DDSS_DEFS_SVH
`define DDSS_DEFS_SVH
`define DDSS_BIT_ERR 15
`define DDSS_TYPE_LO 9
`define DDSS_BIT_ATTN 7
`define DDSS_BIT_WP 6
`define DDSS_BIT_FAULT 4
`define DDSS_BIT_FIRST 3
`define DDSS_BIT_SEEK 2
`define DDSS_RDY_READY 2'h0
`define DDSS_RDY_NODRIVE 2'h2
`define DDSS_RDY_NODISC 2'h3
`define DDSS_TYPE_EMPTY 4'h0
`define DDSS_ERR_NONE 5'h00
`define DDSS_ERR_STATUS 5'h13
`define DDSS_JUMP_NONE 8'h00
`define DDSS_EXTRA_BYTE 8'h01
`define DDSS_STAT_LEN 3'h4
`define DDSS_ADDR_LEN 3'h4
`endif

//--- ddss_pkg.sv
// Purpose: types for the drive status sense block
// Assumes: nothing
// Notes: response kinds
package ddss_pkg;
   typedef enum logic [1:0] {
      DDSS_IDLE = 2'b00,
      DDSS_STAT = 2'b01,
      DDSS_ADDR = 2'b10,
      DDSS_OVER = 2'b11
   } ddss_resp_t;
endpackage : ddss_pkg

//--- ddss_word_if.sv
// Purpose: carries the status word between the two modules
// Assumes: single clock
// Notes: read_clr pulses when the host takes the status
`timescale 1ns/1ps
interface ddss_word_if;
   logic [15:0] word;
   logic read_clr;
   modport prod (output word, input read_clr);
   modport cons (input word, output read_clr);
endinterface : ddss_word_if

//--- ddss_word.sv
// Purpose: holds the sticky flags of the drive status word
// Assumes: event inputs are one-cycle pulses, synchronous
// Notes: a set in the read cycle wins over the clear
`timescale 1ns/1ps
`include "ddss_defs.svh"
module ddss_word
   import ddss_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // drive events
   input wire logic seek_done,
   input wire logic seek_fail,
   input wire logic end_rcvd,
   input wire logic drive_ready,
   input wire logic xfer_active,
   input wire logic hw_fail,
   input wire logic door_closed,
   input wire logic selftest_done,
   input wire logic drive_present,
   input wire logic disc_present,
   input wire logic write_prot,
   input wire logic [3:0] disc_type_field,
   // word out
   ddss_word_if.prod wif
);
   logic attn_r, fault_r, first_r, seek_r, after_end_r;
   logic nodrive_r, por_r, rdy_d_r, disc_d_r, wp_d_r;
   logic [3:0] type_d_r;
   logic [1:0] ready_code;
   logic changed, not_ready_edge;

   // -------------------------------------------------
   // readiness
   // -------------------------------------------------
   // strap-like capture in the first clocked cycle after reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         por_r <= 1'b1;
         nodrive_r <= 1'b0;
      end else if (por_r) begin
         por_r <= 1'b0;
         nodrive_r <= !drive_present;
      end
   end

   always_comb begin
      if (nodrive_r)
         ready_code = `DDSS_RDY_NODRIVE;
      else if (!disc_present)
         ready_code = `DDSS_RDY_NODISC;
      else
         ready_code = `DDSS_RDY_READY;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdy_d_r <= 1'b0;
         disc_d_r <= 1'b0;
         wp_d_r <= 1'b0;
         type_d_r <= `DDSS_TYPE_EMPTY;
         after_end_r <= 1'b0;
      end else begin
         rdy_d_r <= drive_ready;
         disc_d_r <= disc_present;
         wp_d_r <= write_prot;
         type_d_r <= disc_type_field;
         if (end_rcvd)
            after_end_r <= 1'b1;
      end
   end

   assign not_ready_edge = rdy_d_r && !drive_ready;
   assign changed = (disc_d_r != disc_present) || (wp_d_r != write_prot)
                    || (type_d_r != disc_type_field);

   // -------------------------------------------------
   // sticky flags
   // -------------------------------------------------
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         attn_r <= 1'b0;
      else if (seek_done || seek_fail || (after_end_r && changed))
         attn_r <= 1'b1;
      else if (wif.read_clr)
         attn_r <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         fault_r <= 1'b0;
      else if ((not_ready_edge && (after_end_r || xfer_active)) || hw_fail)
         fault_r <= 1'b1;
      else if (wif.read_clr)
         fault_r <= 1'b0;
   end

   // power-on counts as the first cycle after reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         first_r <= 1'b0;
      else if (disc_present && (por_r || door_closed || selftest_done))
         first_r <= 1'b1;
      else if (wif.read_clr)
         first_r <= 1'b0;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         seek_r <= 1'b0;
      else if (seek_fail)
         seek_r <= 1'b1;
      else if (wif.read_clr)
         seek_r <= 1'b0;
   end

   always_comb begin
      wif.word = 16'h0000;
      wif.word[`DDSS_BIT_ERR] = fault_r || seek_r
                                || (ready_code != `DDSS_RDY_READY);
      wif.word[`DDSS_TYPE_LO +: 4] = disc_type_field;
      wif.word[`DDSS_BIT_ATTN] = attn_r;
      wif.word[`DDSS_BIT_WP] = write_prot;
      wif.word[`DDSS_BIT_FAULT] = fault_r;
      wif.word[`DDSS_BIT_FIRST] = first_r;
      wif.word[`DDSS_BIT_SEEK] = seek_r;
      wif.word[1:0] = ready_code;
   end
endmodule : ddss_word

//--- ddss_sense.sv
// Purpose: answers status and logical address sense requests
// Assumes: host handshake via byte_req pulses; untalk is a pulse
// Notes: status reply is error code, jump byte, word high, word low
`timescale 1ns/1ps
`include "ddss_defs.svh"
module ddss_sense
   import ddss_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // drive events
   input wire logic seek_done,
   input wire logic seek_fail,
   input wire logic end_rcvd,
   input wire logic drive_ready,
   input wire logic xfer_active,
   input wire logic hw_fail,
   input wire logic door_closed,
   input wire logic selftest_done,
   input wire logic drive_present,
   input wire logic disc_present,
   input wire logic write_prot,
   input wire logic [3:0] disc_type_field,
   // target address
   input wire logic [15:0] target_cyl,
   input wire logic [7:0] target_head,
   input wire logic [7:0] target_sector,
   // drive operation outcome
   input wire logic op_blocked,
   // host requests
   input wire logic req_status,
   input wire logic req_addr,
   input wire logic byte_req,
   input wire logic untalk,
   // host answers
   output logic [7:0] byte_out,
   output logic byte_valid,
   output logic eoi,
   output logic ppoll_en,
   output logic [4:0] primary_error_code,
   output logic [7:0] jump_byte,
   output logic [15:0] status_word
);
   ddss_word_if wif ();
   ddss_resp_t mode_r, mode_nxt;
   logic [2:0] idx_r;
   logic [31:0] frame_r;
   logic [7:0] byte_out_r;
   logic byte_valid_r, eoi_r, ppoll_r, clr_r;
   logic [4:0] err_r;
   logic [7:0] jump_r;
   logic [15:0] word_r;
   logic last;

   ddss_word u_word (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .seek_done(seek_done),
      .seek_fail(seek_fail),
      .end_rcvd(end_rcvd),
      .drive_ready(drive_ready),
      .xfer_active(xfer_active),
      .hw_fail(hw_fail),
      .door_closed(door_closed),
      .selftest_done(selftest_done),
      .drive_present(drive_present),
      .disc_present(disc_present),
      .write_prot(write_prot),
      .disc_type_field(disc_type_field),
      .wif(wif)
   );

   assign wif.read_clr = clr_r;
   assign last = (idx_r == `DDSS_STAT_LEN - 3'h1);

   // -------------------------------------------------
   // response sequencer
   // -------------------------------------------------
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         DDSS_IDLE: begin
            if (req_status)
               mode_nxt = DDSS_STAT;
            else if (req_addr)
               mode_nxt = DDSS_ADDR;
         end
         DDSS_STAT, DDSS_ADDR: begin
            if (untalk)
               mode_nxt = DDSS_IDLE;
            else if (byte_req && last)
               mode_nxt = DDSS_OVER;
         end
         DDSS_OVER: begin
            if (untalk || byte_req)
               mode_nxt = DDSS_IDLE;
         end
         default: mode_nxt = DDSS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         mode_r <= DDSS_IDLE;
      else
         mode_r <= mode_nxt;
   end

   // reply frame is frozen at request so bytes stay coherent
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         frame_r <= 32'h0000_0000;
         idx_r <= 3'h0;
      end else if (mode_r == DDSS_IDLE && req_status) begin
         frame_r <= {3'h0, `DDSS_ERR_NONE, `DDSS_JUMP_NONE,
                     wif.word};
         idx_r <= 3'h0;
      end else if (mode_r == DDSS_IDLE && req_addr) begin
         frame_r <= {target_cyl, target_head, target_sector};
         idx_r <= 3'h0;
      end else if (byte_req && mode_r != DDSS_IDLE && !last) begin
         idx_r <= idx_r + 3'h1;
      end
   end

   // status flags clear once the status has been taken
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         clr_r <= 1'b0;
      else
         clr_r <= (mode_r == DDSS_IDLE) && req_status;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         byte_out_r <= 8'h00;
         byte_valid_r <= 1'b0;
         eoi_r <= 1'b0;
      end else begin
         byte_valid_r <= 1'b0;
         eoi_r <= 1'b0;
         if (byte_req && (mode_r == DDSS_STAT || mode_r == DDSS_ADDR)) begin
            byte_valid_r <= 1'b1;
            byte_out_r <= frame_r[(5'd24 - {idx_r[1:0], 3'h0}) +: 8];
            eoi_r <= last;
         end else if (byte_req && mode_r == DDSS_OVER) begin
            byte_valid_r <= 1'b1;
            byte_out_r <= `DDSS_EXTRA_BYTE;
            eoi_r <= 1'b1;
         end
      end
   end

   // poll stays off during a reply; a short read waits for untalk
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         ppoll_r <= 1'b1;
      else if (mode_r == DDSS_IDLE && (req_status || req_addr))
         ppoll_r <= 1'b0;
      else if (untalk && mode_r != DDSS_IDLE)
         ppoll_r <= 1'b1;
      else if (mode_r == DDSS_OVER && byte_req)
         ppoll_r <= 1'b1;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         err_r <= `DDSS_ERR_NONE;
         jump_r <= `DDSS_JUMP_NONE;
         word_r <= 16'h0000;
      end else begin
         word_r <= wif.word;
         if (op_blocked && wif.word[`DDSS_BIT_ERR])
            err_r <= `DDSS_ERR_STATUS;
         else if (mode_r == DDSS_IDLE && req_status) begin
            err_r <= `DDSS_ERR_NONE;
            jump_r <= `DDSS_JUMP_NONE;
         end
      end
   end

   assign byte_out = byte_out_r;
   assign byte_valid = byte_valid_r;
   assign eoi = eoi_r;
   assign ppoll_en = ppoll_r;
   assign primary_error_code = err_r;
   assign jump_byte = jump_r;
   assign status_word = word_r;
endmodule : ddss_sense

//--- ddss_sense_assertions.sv
// Purpose: port checks for the drive status sense block
// Assumes: one clock, reset_n asynchronous active low
// Notes: bound to ddss_sense from the bench top file
`timescale 1ns/1ps
`include "ddss_defs.svh"
module ddss_sense_assertions (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // watched inputs
   input wire logic seek_done,
   input wire logic seek_fail,
   input wire logic hw_fail,
   input wire logic door_closed,
   input wire logic selftest_done,
   input wire logic disc_present,
   input wire logic write_prot,
   input wire logic [3:0] disc_type_field,
   input wire logic op_blocked,
   input wire logic req_status,
   input wire logic req_addr,
   input wire logic untalk,
   // watched outputs
   input wire logic eoi,
   input wire logic ppoll_en,
   input wire logic [4:0] primary_error_code,
   input wire logic [15:0] status_word
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire [15:0] w = status_word;
   sequence s_req_idle;
      req_status && ppoll_en;
   endsequence
   // any set source in the window would rightly win over the clear
   sequence s_quiet;
      !(seek_done || seek_fail || hw_fail || door_closed || selftest_done)
         && $stable(write_prot) && $stable(disc_present)
         && $stable(disc_type_field);
   endsequence
   a_sum_err: assert property (w[15] == (w[4] | w[2] | (|w[1:0])))
      else $error("summary bit wrong");
   a_type_follow: assert property (
      ($stable(disc_type_field) && disc_present)[*3]
         |-> w[12:9] == disc_type_field) else $error("disc type wrong");
   a_seek_attn: assert property (seek_done |-> ##[1:3] w[7])
      else $error("attention not set");
   a_read_clr: assert property (
      s_req_idle ##1 s_quiet[*3] |=> (w & 16'h009C) == 16'h0000)
      else $error("sticky flags not cleared");
   a_wp_follow: assert property (
      (write_prot && disc_present)[*3] |-> w[6])
      else $error("write protect bit wrong");
   a_hw_fault: assert property (hw_fail |-> ##[1:3] w[4] && w[15])
      else $error("drive fault not set");
   a_seek_chk: assert property (seek_fail |-> ##[1:3] w[2] && w[7])
      else $error("seek check not set");
   a_no_drive: assert property (
      w[1:0] == `DDSS_RDY_NODRIVE |=> w[1:0] == `DDSS_RDY_NODRIVE)
      else $error("no drive state left");
   a_poll_off: assert property (
      (req_status || req_addr) && ppoll_en |=> !ppoll_en)
      else $error("poll response kept");
   a_poll_on: assert property (
      $rose(ppoll_en) |-> $past(untalk) || eoi || $past(eoi))
      else $error("poll response back early");
   a_blk_code: assert property (
      op_blocked && w[15] |-> ##[1:2] primary_error_code == `DDSS_ERR_STATUS)
      else $error("blocked code wrong");
endmodule : ddss_sense_assertions

//--- ddss_host.sv
// Purpose: bus controller model issuing sense requests
// Assumes: requests change 1 ns after the rising edge
// Notes: records every reply byte with its end flag
`timescale 1ns/1ps
module ddss_host (
   // clock
   input wire logic clk_sys,
   // requests
   output logic req_status,
   output logic req_addr,
   output logic byte_req,
   output logic untalk,
   // answers
   input wire logic [7:0] byte_out,
   input wire logic byte_valid,
   input wire logic eoi
);
   logic [7:0] got [0:7];
   logic got_eoi [0:7];
   int n_got;
   initial begin
      {req_status, req_addr, byte_req, untalk} = 4'h0;
      n_got = 0;
   end
   always @(posedge clk_sys) begin
      if (byte_valid === 1'b1 && n_got < 8) begin
         got[n_got] = byte_out;
         got_eoi[n_got] = eoi;
         n_got = n_got + 1;
      end
   end
   // request, n byte handshakes held high, then optional untalk
   task automatic sense(input logic addr, input int n, input logic ut);
      @(posedge clk_sys);
      #1;
      n_got = 0;
      req_status = !addr;
      req_addr = addr;
      @(posedge clk_sys);
      #1;
      {req_status, req_addr} = 2'h0;
      @(posedge clk_sys);
      #1;
      byte_req = (n > 0);
      repeat (n) @(posedge clk_sys);
      #1;
      byte_req = 1'b0;
      untalk = ut;
      @(posedge clk_sys);
      #1;
      untalk = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask : sense
endmodule : ddss_host

//--- ddss_sense_tb_top.sv
// Purpose: self-checking bench for the drive status sense block
// Assumes: drive ready and no transfer, except one drop of drive_ready during a transfer
// Notes: random targets and events from a fixed lfsr seed
`timescale 1ns/1ps
`include "ddss_defs.svh"
module ddss_sense_tb_top;
   import ddss_pkg::*;
   logic clk_sys, reset_n, seek_done, seek_fail, end_rcvd, drive_ready;
   logic xfer_active, hw_fail, door_closed, selftest_done, drive_present;
   logic disc_present, write_prot, op_blocked, req_status, req_addr;
   logic byte_req, untalk, byte_valid, eoi, ppoll_en;
   logic [3:0] disc_type_field;
   logic [15:0] target_cyl, status_word;
   logic [7:0] target_head, target_sector, byte_out, jump_byte;
   logic [4:0] primary_error_code;
   logic [31:0] lfsr;
   logic a_f, e_f, f_f, c_f, nodrive;
   logic [3:0] types [5] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h8};
   int failures, n_compared, n;
   ddss_sense dut (.clk_sys, .reset_n, .seek_done, .seek_fail, .end_rcvd,
      .drive_ready, .xfer_active, .hw_fail, .door_closed, .selftest_done,
      .drive_present, .disc_present, .write_prot, .disc_type_field,
      .target_cyl, .target_head, .target_sector, .op_blocked, .req_status,
      .req_addr, .byte_req, .untalk, .byte_out, .byte_valid, .eoi, .ppoll_en,
      .primary_error_code, .jump_byte, .status_word);
   ddss_host host (.clk_sys, .req_status, .req_addr, .byte_req, .untalk,
      .byte_out, .byte_valid, .eoi);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   function automatic logic [15:0] exp_word();
      logic [1:0] rdy;
      rdy = nodrive ? 2'h2 : (disc_present ? 2'h0 : 2'h3);
      return {e_f | c_f | (|rdy), 2'h0, disc_type_field, 1'b0, a_f,
         write_prot, 1'b0, e_f, f_f, c_f, rdy};
   endfunction : exp_word
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic pulse(ref logic s);
      @(posedge clk_sys);
      #1;
      s = 1'b1;
      @(posedge clk_sys);
      #1;
      s = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : pulse
   task automatic do_reset(input logic present);
      reset_n = 1'b0;
      drive_present = present;
      nodrive = !present;
      repeat (16) @(posedge clk_sys);
      #1;
      reset_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      {a_f, e_f, c_f} = 3'h0;
      f_f = disc_present & present;
   endtask : do_reset
   task automatic read_status(input int n, input logic ut);
      logic [31:0] exp_b;
      exp_b = {8'h00, `DDSS_JUMP_NONE, exp_word()};
      host.sense(1'b0, n, ut);
      check("byte count", host.n_got, n);
      for (int i = 0; i < 4 && i < n; i++) begin
         check("stat", host.got[i], exp_b[31-8*i -: 8]);
      end
      if (n > 3) check("eoi", host.got_eoi[3], 1'b1);
      if (n > 4) check("extra", {host.got[4], host.got_eoi[4]}, 9'h003);
      check("ppoll", ppoll_en, ut || n > 4);
      check("code", {jump_byte, primary_error_code}, 13'h0);
      {a_f, e_f, f_f, c_f} = 4'h0;
      check("word", status_word, exp_word());
   endtask : read_status
   task automatic read_addr();
      logic [31:0] exp_b;
      exp_b = {target_cyl, target_head, target_sector};
      host.sense(1'b1, 4, 1'b1);
      for (int i = 0; i < 4; i++) begin
         check("addr", host.got[i], exp_b[31-8*i -: 8]);
      end
      check("addr eoi", host.got_eoi[3], 1'b1);
   endtask : read_addr
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {seek_done, seek_fail, end_rcvd, xfer_active, hw_fail} = 5'h00;
      {door_closed, selftest_done, op_blocked, write_prot} = 4'h0;
      {drive_ready, disc_present, disc_type_field} = 6'h32;
      {target_cyl, target_head, target_sector} = 32'h0;
      {failures, n_compared, lfsr} = {32'h0, 32'h0, 32'hF74A};
      do_reset(1'b1);
      read_status(5, 1'b0);
      foreach (types[i]) begin
         lfsr = lfsr_next(lfsr);
         {disc_type_field, write_prot} = {types[i], lfsr[0]};
         read_status(4, 1'b1);
      end
      pulse(door_closed);
      f_f = 1'b1;
      read_status(2, 1'b0);
      host.sense(1'b0, 0, 1'b1);
      check("ppoll untalk", ppoll_en, 1'b1);
      pulse(selftest_done);
      f_f = 1'b1;
      read_status(4, 1'b1);
      pulse(end_rcvd);
      write_prot = !write_prot;
      a_f = 1'b1;
      read_status(4, 1'b1);
      $display("test corner cases done");
      repeat (8) begin
         lfsr = lfsr_next(lfsr);
         if (lfsr[0]) pulse(seek_done);
         if (lfsr[1]) pulse(hw_fail);
         if (lfsr[2]) pulse(seek_fail);
         {a_f, e_f, c_f} = {lfsr[0] | lfsr[2], lfsr[1], lfsr[2]};
         {target_cyl, target_head, target_sector} = lfsr;
         read_addr();
         n = lfsr[5:3] % 3 + 3;
         read_status(n, n != 5 || lfsr[6]);
      end
      $display("test random events done");
      xfer_active = 1'b1;
      pulse(drive_ready);
      {drive_ready, xfer_active} = 2'b10;
      e_f = 1'b1;
      read_status(4, 1'b1);
      pulse(seek_fail);
      pulse(op_blocked);
      check("blocked", primary_error_code, `DDSS_ERR_STATUS);
      {disc_present, write_prot, disc_type_field} = 6'h00;
      {a_f, c_f} = 2'h3;
      read_status(4, 1'b1);
      do_reset(1'b0);
      drive_present = 1'b1;
      read_status(4, 1'b1);
      $display("test no drive done");
      stop_test();
   end
   // whole run needs well under 25000 cycles
   initial begin
      #200000;
      failures++;
      stop_test();
   end
   task automatic stop_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
endmodule : ddss_sense_tb_top
bind ddss_sense ddss_sense_assertions u_chk (.clk_sys, .reset_n, .seek_done,
   .seek_fail, .hw_fail, .door_closed, .selftest_done, .disc_present,
   .write_prot, .disc_type_field, .op_blocked, .req_status, .req_addr,
   .untalk, .eoi, .ppoll_en, .primary_error_code, .status_word);
